//--- hw/spi_cfg_pkg.sv
// Package: constants and types for the serial port configuration block
// How it works
// [R1] Bits 7..4 of the first configuration register read back copies of bits 0, 1, 2 and 3.
// [R2] Bit 3 set selects 4-wire operation with a separate data-out line, clear selects 3-wire.
// [R3] In streaming transfers the address steps up after each byte when bit 2 is 1, down when 0.
// [R4] Bit 1 set shifts input and output data least significant bit first, clear most significant first.
// [R5] Writing 1 to bit 0 starts an internal reset and the bit clears itself when the reset is done.
// [R6] Bit 7 of the second configuration register at 1 selects single transfers, at 0 streaming.
// [R7] Bit 6 of the second configuration register at 1 enables chip-select stalling, at 0 disables it; csb high ends the transfer here whatever bit 6 holds.
// [R8] The low product identification byte is read-only and valid only after the boot loader is done.
// [R9] An 8-bit read-only chip type value sits at its own register beside the product identification.
// [R10] During a soft reset register writes are ignored and afterwards all settings return to reset values.
package spi_cfg_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [14:0] ADDR_CONFIG_A = 15'h0000;
  localparam logic [14:0] ADDR_CONFIG_B = 15'h0001;
  localparam logic [14:0] ADDR_CATEGORY = 15'h0003;
  localparam logic [14:0] ADDR_PROD_LOW = 15'h0004;
  localparam logic [7:0]  CONFIG_A_RST  = 8'h00;
  localparam logic [7:0]  CONFIG_B_RST  = 8'h00;
  localparam logic [7:0]  ID_INVALID    = 8'h00;
  // Field positions
  localparam int BIT_RESET   = 0;
  localparam int BIT_ORDER   = 1;
  localparam int BIT_DIR     = 2;
  localparam int BIT_FOUR    = 3;
  localparam int BIT_SINGLE  = 7;
  localparam int BIT_STALL   = 6;
  localparam int INSTR_BITS  = 16;
  localparam int BYTE_BITS   = 8;
  // Soft reset hold, in clock cycles
  localparam int SOFT_RST_CYCLES = 16;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_INSTR = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_DONE  = 4'b1000
  } xfer_state_t;

  // Settings driven onto the serial engine
  typedef struct packed {
    logic four_wire_select;
    logic stream_address_direction;
    logic bit_order_select;
    logic single_transfer_select;
    logic select_line_stall_enable;
  } port_cfg_t;

  // Serial pins after synchronisation
  typedef struct packed {
    logic sclk;
    logic csb;
    logic sdio;
  } pins_t;
endpackage

//--- hw/pin_sync.sv
// Three-stage synchroniser with agreement filter for serial pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import spi_cfg_pkg::*;
#(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Raw and clean pins
  input  wire logic [WIDTH-1:0] raw,
  output var  logic [WIDTH-1:0] clean
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.out[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '{s1: '1, s2: '1, s3: '1, out: '1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clean = st_r.out;
endmodule
`default_nettype wire

//--- hw/spi_config_regs.sv
// Serial port slave with interface configuration and identification registers
`timescale 1ns/1ps
`default_nettype none
module spi_config_regs
  import spi_cfg_pkg::*;
#(
  parameter logic [7:0] CATEGORY_VALUE = 8'hA5, // Arbitrary value
  parameter logic [7:0] PRODUCT_VALUE  = 8'h5A  // Arbitrary value
) (
  // Clock and reset
  input  wire logic      sys_clk,
  input  wire logic      rst,
  // Boot status
  input  wire logic      boot_done,
  // Serial pins
  input  wire logic      sclk,
  input  wire logic      csb_n,
  input  wire logic      sdio_in,
  output logic           sdio_out,
  output logic           sdio_oe_n,
  output logic           sdo,
  output logic           sdo_oe_n,
  // Settings and internal reset
  output port_cfg_t      port_cfg,
  output logic           soft_rst
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    xfer_state_t  fsm;
    logic         sclk_d;
    logic [4:0]   cnt;
    logic [15:0]  shreg;
    logic         rnw;
    logic [14:0]  addr;
    logic [7:0]   txb;
    logic [7:0]   cfg_a;
    logic [7:0]   cfg_b;
    logic [7:0]   rst_cnt;
    logic         in_rst;
    logic         out_bit;
    logic         drive_io;
    logic         drive_so;
    port_cfg_t    cfg;
  } regs_t;

  regs_t st_r;
  regs_t st_nxt;
  pins_t pins;

  pin_sync #(.WIDTH(3)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .raw     ({sclk, csb_n, sdio_in}),
    .clean   (pins)
  );

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  function automatic logic [7:0] read_reg(input logic [14:0] a, input logic [7:0] ca,
                                          input logic [7:0] cb, input logic bd);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ADDR_CONFIG_A: v = {ca[0], ca[1], ca[2], ca[3], ca[3:0]}; // [R1]
      ADDR_CONFIG_B: v = cb;
      ADDR_CATEGORY: v = CATEGORY_VALUE; // [R9]
      ADDR_PROD_LOW: v = bd ? PRODUCT_VALUE : ID_INVALID; // [R8]
      default:       v = 8'h00;
    endcase
    return v;
  endfunction

  // Bit picked out of a byte by position and order
  function automatic logic pick(input logic [7:0] b, input logic [2:0] i, input logic lsb);
    return lsb ? b[i] : b[3'h7 - i]; // [R4]
  endfunction

  logic rise;
  logic fall;
  logic [7:0] rx_byte;
  logic [7:0] ser_next;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_d = pins.sclk;
    rise = pins.sclk & ~st_r.sclk_d;
    fall = ~pins.sclk & st_r.sclk_d;
    rx_byte = st_r.shreg[7:0];
    ser_next = 8'h00;
    // Bits arrive in shift order; reverse when least significant first
    if (st_r.cfg.bit_order_select) begin
      for (int i = 0; i < BYTE_BITS; i++) begin
        rx_byte[i] = st_r.shreg[7 - i]; // [R4]
      end
    end
    if (st_r.in_rst) begin
      // Writes ignored while the internal reset runs
      if (st_r.rst_cnt == 8'(SOFT_RST_CYCLES - 1)) begin // [R10]
        st_nxt.in_rst = 1'b0;
        st_nxt.cfg_a = CONFIG_A_RST; // [R5]
        st_nxt.cfg_b = CONFIG_B_RST; // [R10]
        st_nxt.rst_cnt = 8'h00;
      end else begin
        st_nxt.rst_cnt = st_r.rst_cnt + 8'h01;
      end
    end
    if (pins.csb) begin
      st_nxt.fsm = ST_IDLE;
      st_nxt.drive_io = 1'b0;
      st_nxt.drive_so = 1'b0;
    end else begin
      unique case (st_r.fsm)
        ST_IDLE: begin
          st_nxt.fsm = ST_INSTR;
          st_nxt.cnt = 5'h00;
        end
        ST_INSTR: begin
          if (rise) begin
            st_nxt.shreg = {st_r.shreg[14:0], pins.sdio};
            st_nxt.cnt = st_r.cnt + 5'h01;
            if (st_r.cnt == 5'(INSTR_BITS - 1)) begin
              // Least significant first reverses the whole word, so direction comes last
              st_nxt.rnw = st_r.cfg.bit_order_select ? pins.sdio : st_r.shreg[14]; // [R4]
              st_nxt.addr = st_r.cfg.bit_order_select ? 15'h0000 : {st_r.shreg[13:0], pins.sdio};
              if (st_r.cfg.bit_order_select) begin
                for (int i = 0; i < 15; i++) begin
                  st_nxt.addr[i] = st_r.shreg[14 - i]; // [R4]
                end
              end
              st_nxt.cnt = 5'h00;
              st_nxt.fsm = ST_DATA;
              st_nxt.txb = 8'h00;
            end
          end
        end
        ST_DATA: begin
          if (st_r.cnt == 5'h00 && !rise) begin
            st_nxt.txb = read_reg(st_r.addr, st_r.cfg_a, st_r.cfg_b, boot_done);
          end
          // First bit of a byte waits for clock low so it never moves under a high clock
          if (fall || (st_r.cnt == 5'h00 && !rise && !pins.sclk)) begin
            ser_next = (st_r.cnt == 5'h00) ? read_reg(st_r.addr, st_r.cfg_a, st_r.cfg_b, boot_done)
                                           : st_r.txb;
            st_nxt.out_bit = pick(ser_next, st_r.cnt[2:0], st_r.cfg.bit_order_select);
            st_nxt.drive_io = st_r.rnw & ~st_r.cfg.four_wire_select; // [R2]
            st_nxt.drive_so = st_r.rnw & st_r.cfg.four_wire_select; // [R2]
          end
          if (rise) begin
            st_nxt.shreg = {st_r.shreg[14:0], pins.sdio};
            st_nxt.cnt = st_r.cnt + 5'h01;
            if (st_r.cnt == 5'(BYTE_BITS - 1)) begin
              st_nxt.cnt = 5'h00;
              if (!st_r.rnw && !st_r.in_rst) begin // [R10]
                rx_byte = st_r.cfg.bit_order_select ? 8'h00 : {st_r.shreg[6:0], pins.sdio};
                if (st_r.cfg.bit_order_select) begin
                  for (int i = 0; i < BYTE_BITS; i++) begin
                    rx_byte[i] = (i == 7) ? pins.sdio : st_r.shreg[6 - i];
                  end
                end
                if (st_r.addr == ADDR_CONFIG_A) begin
                  st_nxt.cfg_a = {4'h0, rx_byte[3:0]};
                  if (rx_byte[BIT_RESET]) begin // [R5]
                    st_nxt.in_rst = 1'b1;
                    st_nxt.rst_cnt = 8'h00;
                  end
                end else if (st_r.addr == ADDR_CONFIG_B) begin
                  st_nxt.cfg_b = rx_byte;
                end
              end
              if (st_r.cfg.single_transfer_select) begin // [R6]
                st_nxt.fsm = ST_DONE;
              end else if (st_r.cfg.stream_address_direction) begin // [R3]
                st_nxt.addr = st_r.addr + 15'h0001;
              end else begin
                st_nxt.addr = st_r.addr - 15'h0001; // [R3]
              end
            end
          end
        end
        ST_DONE: begin
          st_nxt.drive_io = 1'b0;
          st_nxt.drive_so = 1'b0;
        end
        default: st_nxt.fsm = ST_IDLE;
      endcase
    end
    // First-register settings apply between transfers, so a frame changes format midway only when a soft reset ends during it; second-register bits apply at once
    // Settings hold still through a soft reset and take the cleared values at its end
    if ((pins.csb || st_r.in_rst) && !st_nxt.in_rst) begin // [R10]
      st_nxt.cfg.four_wire_select         = st_nxt.cfg_a[BIT_FOUR];
      st_nxt.cfg.stream_address_direction = st_nxt.cfg_a[BIT_DIR];
      st_nxt.cfg.bit_order_select         = st_nxt.cfg_a[BIT_ORDER];
    end
    st_nxt.cfg.single_transfer_select   = st_nxt.cfg_b[BIT_SINGLE]; // [R6]
    st_nxt.cfg.select_line_stall_enable = st_nxt.cfg_b[BIT_STALL]; // [R7]
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '{fsm: ST_IDLE, sclk_d: 1'b1, cnt: 5'h00, shreg: 16'h0000, rnw: 1'b0,
                addr: 15'h0000, txb: 8'h00, cfg_a: CONFIG_A_RST, cfg_b: CONFIG_B_RST,
                rst_cnt: 8'h00, in_rst: 1'b0, out_bit: 1'b0, drive_io: 1'b0,
                drive_so: 1'b0, cfg: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sdio_out  = st_r.out_bit;
  assign sdio_oe_n = ~st_r.drive_io;
  assign sdo       = st_r.out_bit;
  assign sdo_oe_n  = ~st_r.drive_so;
  assign port_cfg  = st_r.cfg;
  assign soft_rst  = st_r.in_rst; // [R5]
endmodule
`default_nettype wire

//--- bench/spi_config_regs_props.sv
// Assertion checker for the serial configuration block
`timescale 1ns/1ps
`default_nettype none
module spi_config_regs_props
  import spi_cfg_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins and settings
  input wire logic boot_done,
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe_n,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  input wire port_cfg_t port_cfg,
  input wire logic soft_rst
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Length of the current soft reset; a repetition of 16 would be too costly
  logic [5:0] run_r;
  logic [5:0] run_nxt;
  assign run_nxt = soft_rst ? run_r + 6'h01 : 6'h00;
  always_ff @(posedge sys_clk) run_r <= rst ? 6'h00 : run_nxt;
  one_driver_a: assert property (sdio_oe_n || sdo_oe_n) else $error("both lines driven");
  four_wire_a: assert property (!sdo_oe_n |-> port_cfg.four_wire_select) else $error("sdo in 3-wire");
  three_wire_a: assert property (!sdio_oe_n |-> !port_cfg.four_wire_select) else $error("sdio in 4-wire");
  idle_release_a: assert property (csb_n [*8] |-> sdio_oe_n && sdo_oe_n) else $error("driven unselected");
  bit_hold_a: assert property (!sdo_oe_n && sclk && $past(sclk) |-> $stable(sdo)) else $error("sdo moved");
  reset_len_a: assert property ($fell(soft_rst) |-> run_r == 6'h10) else $error("soft reset length");
  reset_clear_a: assert property ($fell(soft_rst) |-> ##[0:2] port_cfg == '0) else $error("settings kept");
  reset_freeze_a: assert property (soft_rst && $past(soft_rst) |-> $stable(port_cfg)) else $error("write taken");
  cover property ($rose(soft_rst));
  cover property (!sdo_oe_n);
  cover property (!sdio_oe_n);
endmodule
`default_nettype wire

//--- bench/spi_host.sv
// Serial host model that issues register frames
`timescale 1ns/1ps
`default_nettype none
module spi_host (
  // Clock
  input wire logic sys_clk,
  // Serial pins
  output var logic sclk,
  output var logic csb_n,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe_n,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  logic lsb = 1'b0;
  logic four = 1'b0;
  logic drv = 1'b0;
  logic released = 1'b0;
  logic [7:0] rd [2];
  logic [1:0] hiz;
  // A released line toggles so that a stale bit never passes for data
  assign sdio_in = sdio_oe_n ? drv : sdio_out;
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
  end
  task automatic half();
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic bits(input logic [15:0] w, input int n, output logic [15:0] r, output logic z);
    int i;
    r = '0;
    z = 1'b0;
    for (int k = 0; k < n; k++) begin
      i = lsb ? k : n - 1 - k;
      sclk <= 1'b0;
      drv <= released ? ~drv : w[i];
      half();
      r[i] = four ? sdo : sdio_in;
      z = z | (four ? sdo_oe_n : sdio_oe_n);
      sclk <= 1'b1;
      half();
    end
  endtask
  task automatic frame(input logic rw, input logic [14:0] a, input int nb, input logic [7:0] wd);
    logic [15:0] r;
    logic z;
    csb_n <= 1'b0;
    half();
    bits({rw, a}, 16, r, z);
    released <= rw && !four;
    for (int b = 0; b < nb; b++) begin
      bits({8'h00, wd}, 8, r, z);
      rd[b] = r[7:0];
      hiz[b] = z;
    end
    sclk <= 1'b0;
    released <= 1'b0;
    half();
    csb_n <= 1'b1;
    half();
    half();
  endtask
endmodule
`default_nettype wire

//--- bench/tb_spi_config_regs.sv
// Self-checking bench for the serial configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_spi_config_regs;
  import spi_cfg_pkg::*;
  logic sys_clk;
  logic rst;
  logic boot_done;
  logic sclk, csb_n, sdio_in, sdio_out, sdio_oe_n, sdo, sdo_oe_n, soft_rst;
  port_cfg_t port_cfg;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  spi_config_regs DUT (.*);
  spi_host host (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Far beyond the roughly 6630 cycles the frames need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic summarize();
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host.frame(1'b0, a, 1, d);
  endtask
  task automatic rd(input string nm, input logic [14:0] a, input int n, input logic [7:0] e0, input logic [7:0] e1);
    host.frame(1'b1, a, n, 8'h00);
    chk(nm, e0, host.rd[0]);
    if (n > 1) chk(nm, e1, host.rd[1]);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    boot_done = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rd("config_a", ADDR_CONFIG_A, 1, CONFIG_A_RST, 8'h00);
    rd("config_b", ADDR_CONFIG_B, 1, CONFIG_B_RST, 8'h00);
    rd("prod_boot", ADDR_PROD_LOW, 1, ID_INVALID, 8'h00);
    boot_done <= 1'b1;
    wr(ADDR_CATEGORY, 8'h00);
    rd("down", ADDR_PROD_LOW, 2, 8'h5A, 8'hA5);
    rd("spare", 15'h0002, 1, 8'h00, 8'h00);
    wr(ADDR_CONFIG_A, 8'hFE);
    host.four = 1'b1;
    host.lsb = 1'b1;
    chk("port_cfg", 8'h1C, {3'b000, port_cfg});
    rd("config_a", ADDR_CONFIG_A, 1, 8'h7E, 8'h00);
    rd("up", ADDR_CATEGORY, 2, 8'hA5, 8'h5A);
    wr(ADDR_CONFIG_B, 8'hC5);
    chk("port_cfg", 8'h1F, {3'b000, port_cfg});
    rd("config_b", ADDR_CONFIG_B, 1, 8'hC5, 8'h00);
    host.frame(1'b1, ADDR_CATEGORY, 2, 8'h00);
    chk("single", 8'hA5, host.rd[0]);
    chk("single_end", 8'h02, {6'h00, host.hiz});
    wr(ADDR_CONFIG_A, 8'h01);
    for (int i = 0; i < 40 && soft_rst !== 1'b0; i++) @(posedge sys_clk);
    host.four = 1'b0;
    host.lsb = 1'b0;
    chk("port_cfg", 8'h00, {3'b000, port_cfg});
    rd("config_a", ADDR_CONFIG_A, 1, CONFIG_A_RST, 8'h00);
    rd("config_b", ADDR_CONFIG_B, 1, CONFIG_B_RST, 8'h00);
    summarize();
  end
endmodule
bind spi_config_regs spi_config_regs_props props (.*);
`default_nettype wire
